// [pkg/odc_map.svh]
// constants of the oled display state controller: offsets, codes, defaults, timing
`ifndef ODC_MAP_SVH
`define ODC_MAP_SVH
// Summary of operation
// R01 - hardware reset: display off, oscillator stopped, defaults
// R02 - frame memory 128 x 160 x 16 bits
// R03 - inactive columns always at pre-charge
// R04 - inactive rows at supply, never scanned
// R05 - scan repeats over selected rows only
// R06 - line timing fixed for any area
// R07 - pixel writes stay inside writing box
// R08 - address steps per writing direction
// R09 - scroll reads whole frame memory
// R10 - display reading starts at start address
// R11 - gray level maps to pulse width
// R12 - display off only blanks outputs
// R13 - standby blanks outputs, stops oscillator
// R14 - soft reset: off, defaults, standby
// R15 - dot clock nominal 4.08 MHz
// R16 - overlap shifts row falling moment
// R17 - display off: pre-charge, ground, no transfer
// R18 - frame rate from line and 160 rows; code scans only the active rows per frame
// R19 - host keeps bounds ordered, in range
// R20 - standby parameter starts or stops oscillator
// R21 - drivers dark until running and on
// R22 - pulse counted from data period start

// ---------------------------------------------
// register offsets
// ---------------------------------------------
`define ODC_OFF_CMD     8'h00
`define ODC_OFF_PARAM   8'h04
`define ODC_OFF_TIMING  8'h08
`define ODC_OFF_STATUS  8'h0C
`define ODC_OFF_AREA    8'h10

// ---------------------------------------------
// command codes and defaults
// ---------------------------------------------
`define ODC_CMD_SOFT    8'h01
`define ODC_CMD_DISP    8'h02
`define ODC_CMD_STBY    8'h03
`define ODC_CMD_FRAME   8'h04
`define ODC_CMD_WDIR    8'h05
`define ODC_CMD_SDIR    8'h06
`define ODC_CMD_AREA    8'h07
`define ODC_CMD_BOX     8'h0A
`define ODC_CMD_START   8'h0B
`define ODC_CMD_DATA    8'h0C
`define ODC_FRAME_DEF   3'h2
`define ODC_X_MAX       7'h7F
`define ODC_Y_MAX       8'h9F
// overlap 0, peak delay 1, peak width 10, pre-charge width 16
`define ODC_TIMING_DEF  32'h0001_0A10
`define ODC_RESP_OKAY   2'h0
`define ODC_RESP_SLVERR 2'h2

// ---------------------------------------------
// timing
// ---------------------------------------------
// system clock 100 MHz, dot clock 4.08 MHz
`define ODC_CLK_HZ      64'h0000_0000_05F5_E100
`define ODC_DOT_HZ      64'h0000_0000_003E_4180
`define ODC_HZ_60       64'h0000_0000_0000_003C
`define ODC_HZ_75       64'h0000_0000_0000_004B
`define ODC_HZ_90       64'h0000_0000_0000_005A
`define ODC_HZ_105      64'h0000_0000_0000_0069
`define ODC_HZ_120      64'h0000_0000_0000_0078
`define ODC_LINE_DATA   10'h100
`define ODC_GRAY_STEP   8'h04
`define ODC_GRAY_MAX_L  6'h3F
`define ODC_GRAY_MAX_W  8'hFF
`endif

// [pkg/odc_pkg.sv]
// types of the oled display state controller
package odc_pkg;
    // pixel write sequencer
    typedef enum logic {
        wr_idle,
        wr_busy
    } odc_wr_state_t;

    // one 16-bit pixel as held in frame memory
    typedef struct packed {
        logic [4:0] r;
        logic [5:0] g;
        logic [4:0] b;
    } odc_pixel_t;
endpackage : odc_pkg

// [pkg/odc_mem_if.sv]
// frame memory port bundle between the controller and its memory
interface odc_mem_if #(
    parameter int AW = 15,
    parameter int DW = 16
);
    logic          we;
    logic [AW-1:0] waddr;
    logic [DW-1:0] wdata;
    logic [AW-1:0] raddr;
    logic [DW-1:0] rdata;

    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : odc_mem_if

// [core/odc_frame_mem.sv]
// frame memory: one write port, one read port with registered read data
module odc_frame_mem #(
    parameter int DEPTH = 20480,
    parameter int WIDTH = 16
) (
    // clock
    input wire logic aclk,
    // memory port
    odc_mem_if.mem   mp
);
    logic [WIDTH-1:0] store [DEPTH];

    // write port, no reset: image contents survive every reset
    always_ff @(posedge aclk) begin : mem_write
        if (mp.we) begin
            store[mp.waddr] <= mp.wdata;
        end
    end

    // read port, data one cycle after the address
    always_ff @(posedge aclk) begin : mem_read
        mp.rdata <= store[mp.raddr];
    end
endmodule : odc_frame_mem

// [core/odc_display_ctrl.sv]
// display state control: host commands, frame memory writes, row scan, column drive
//
// Our own choices: the AXI4-Lite slave port and the register addresses.
`include "odc_map.svh"

module odc_display_ctrl #(
    parameter int NCOL = 128,
    parameter int NROW = 160
) (
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // axi4-lite write address and data
    input  wire logic [7:0]        awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    // axi4-lite write response
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // axi4-lite read
    input  wire logic [7:0]        araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // panel drivers
    output logic [3*NCOL-1:0]      col_pre,
    output logic [3*NCOL-1:0]      col_drive,
    output logic [NROW-1:0]        row_gnd
);
    localparam int XW = $clog2(NCOL);
    localparam int YW = $clog2(NROW);

    // ---------------------------------------------
    // declarations
    // ---------------------------------------------
    logic [7:0]                aw_q;
    logic [31:0]               w_q;
    logic [3:0]                ws_q;
    logic                      wr_fire, cmd_hit, par_hit;
    logic                      defaults;
    logic [7:0]                cmd;
    logic [2:0]                pidx;
    logic [31:0]               stage, next_stage;
    logic                      disp_on;
    logic                      standby;
    logic [2:0]                frame_sel;
    logic [1:0]                wdir;
    logic                      scan_dir;
    logic [XW-1:0]             ax_s, ax_e, bx_s, bx_e, st_x, wx;
    logic [YW-1:0]             ay_s, ay_e, by_s, by_e, st_y, wy;
    logic [31:0]               timing;
    odc_pkg::odc_wr_state_t    wr_state;
    logic                      box_done;
    logic                      data_start;
    logic                      px_fire;
    logic                      x_end, y_end;
    logic [XW-1:0]             lx_s, lx_e;
    logic [YW-1:0]             ly_s, ly_e;
    logic                      osc_run, lit;
    logic [7:0]                osc_cnt;
    logic                      dot_tick;
    logic [9:0]                line_pos, line_len, pk_end;
    logic [YW-1:0]             cur_row, fetch_row;
    logic [XW:0]               fc;
    logic [XW-1:0]             fc_d;
    logic                      fv;
    odc_pkg::odc_pixel_t       line_buf  [NCOL];
    odc_pkg::odc_pixel_t       fetch_buf [NCOL];

    odc_mem_if #(.AW(XW + YW), .DW(16)) mem_bus ();

    // ---------------------------------------------
    // functions
    // ---------------------------------------------
    // dot clock divider for the frame rate selection
    function automatic logic [7:0] osc_div(input logic [2:0] sel);
        logic [63:0] hz;
        case (sel)
            3'h0:    hz = `ODC_HZ_60;
            3'h1:    hz = `ODC_HZ_75;
            3'h3:    hz = `ODC_HZ_105;
            3'h4:    hz = `ODC_HZ_120;
            default: hz = `ODC_HZ_90;
        endcase
        osc_div = 8'(`ODC_CLK_HZ * `ODC_HZ_90 / (`ODC_DOT_HZ * hz));
    endfunction : osc_div

    // gray level to pulse width in dot clocks
    function automatic logic [7:0] gray_width(input logic [5:0] lvl);
        if (lvl == `ODC_GRAY_MAX_L) begin
            gray_width = `ODC_GRAY_MAX_W;
        end else begin
            gray_width = 8'(8'(lvl) * `ODC_GRAY_STEP);
        end
    endfunction : gray_width

    // pulse width of sub-pixel k of a pixel, 5-bit colours widened to 6 bits
    function automatic logic [7:0] sub_w(input odc_pkg::odc_pixel_t p, input int k);
        case (k)
            0:       sub_w = gray_width({p.r, p.r[4]});
            1:       sub_w = gray_width(p.g);
            default: sub_w = gray_width({p.b, p.b[4]});
        endcase
    endfunction : sub_w

    // next row of the scan inside the active rows
    function automatic logic [YW-1:0] row_step(input logic [YW-1:0] r);
        if (!scan_dir) begin
            row_step = (r >= ay_e || r < ay_s) ? ay_s : YW'(r + 1'b1);
        end else begin
            row_step = (r <= ay_s || r > ay_e) ? ay_e : YW'(r - 1'b1);
        end
    endfunction : row_step

    // memory row for a display row, wrapping over the whole memory
    function automatic logic [YW-1:0] mem_row(input logic [YW-1:0] r);
        logic [YW+1:0] t;
        t = (YW+2)'(st_y) + (YW+2)'(r) + (YW+2)'(NROW) - (YW+2)'(ay_s);
        if (t >= (YW+2)'(2 * NROW)) begin
            t = t - (YW+2)'(2 * NROW);
        end else if (t >= (YW+2)'(NROW)) begin
            t = t - (YW+2)'(NROW);
        end
        mem_row = YW'(t);
    endfunction : mem_row

    // ---------------------------------------------
    // axi4-lite slave
    // ---------------------------------------------
    // both halves of a write are held until the response leaves
    assign wr_fire = !awready && !wready && !bvalid;
    assign cmd_hit = wr_fire && aw_q == `ODC_OFF_CMD && ws_q[0];
    assign par_hit = wr_fire && aw_q == `ODC_OFF_PARAM && ws_q[0];

    // write channels and response
    always_ff @(posedge aclk) begin : axi_write
        if (!aresetn) begin
            awready <= 1'b1;
            wready  <= 1'b1;
            bvalid  <= 1'b0;
            bresp   <= `ODC_RESP_OKAY;
            aw_q    <= '0;
            w_q     <= '0;
            ws_q    <= '0;
        end else begin
            if (awvalid && awready) begin
                aw_q    <= awaddr;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                w_q    <= wdata;
                ws_q   <= wstrb;
                wready <= 1'b0;
            end
            if (wr_fire) begin
                bvalid <= 1'b1;
                case (aw_q)
                    `ODC_OFF_CMD, `ODC_OFF_PARAM, `ODC_OFF_TIMING,
                    `ODC_OFF_STATUS, `ODC_OFF_AREA: bresp <= `ODC_RESP_OKAY;
                    default:                        bresp <= `ODC_RESP_SLVERR;
                endcase
            end
            if (bvalid && bready) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // read channel, data one cycle after the address is taken
    always_ff @(posedge aclk) begin : axi_read
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= `ODC_RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rresp   <= `ODC_RESP_OKAY;
            case (araddr)
                `ODC_OFF_CMD:    rdata <= {24'h00_0000, cmd};
                `ODC_OFF_PARAM:  rdata <= {29'h0000_0000, pidx};
                `ODC_OFF_TIMING: rdata <= timing;
                `ODC_OFF_STATUS: rdata <= {1'b0, wx, wy, cur_row, 4'h0,
                                           wr_state == odc_pkg::wr_busy,
                                           osc_run, standby, disp_on};
                `ODC_OFF_AREA:   rdata <= {ay_e, ay_s, 1'b0, ax_e, 1'b0, ax_s};
                default: begin
                    rdata <= '0;
                    rresp <= `ODC_RESP_SLVERR;
                end
            endcase
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    // ---------------------------------------------
    // command decoding and configuration
    // ---------------------------------------------
    // R14 soft reset loads defaults
    assign defaults   = !aresetn || (cmd_hit && w_q[7:0] == `ODC_CMD_SOFT);
    assign next_stage = {stage[27:0], w_q[3:0]};
    assign box_done   = par_hit && cmd == `ODC_CMD_BOX && pidx == 3'h7;
    assign data_start = cmd_hit && w_q[7:0] == `ODC_CMD_DATA;

    // parameters arrive one nibble each, upper nibble first
    always_ff @(posedge aclk) begin : cmd_regs
        // R01 reset state and defaults
        if (defaults) begin
            cmd       <= '0;
            pidx      <= '0;
            stage     <= '0;
            disp_on   <= 1'b0;
            standby   <= 1'b1;
            frame_sel <= `ODC_FRAME_DEF;
            wdir      <= '0;
            scan_dir  <= 1'b0;
            ax_s      <= '0;
            ax_e      <= `ODC_X_MAX;
            ay_s      <= '0;
            ay_e      <= `ODC_Y_MAX;
            bx_s      <= '0;
            bx_e      <= `ODC_X_MAX;
            by_s      <= '0;
            by_e      <= `ODC_Y_MAX;
            st_x      <= '0;
            st_y      <= '0;
            timing    <= `ODC_TIMING_DEF;
        end else begin
            if (cmd_hit) begin
                cmd  <= w_q[7:0];
                pidx <= '0;
            end else if (par_hit) begin
                pidx  <= 3'(pidx + 1'b1);
                stage <= next_stage;
                case (cmd)
                    // R12 only the display flag moves
                    `ODC_CMD_DISP: disp_on <= w_q[0];
                    // R13 R20 standby stops oscillator and blanks
                    `ODC_CMD_STBY: begin
                        standby <= w_q[0];
                        if (w_q[0]) begin
                            disp_on <= 1'b0;
                        end
                    end
                    `ODC_CMD_FRAME: frame_sel <= w_q[2:0];
                    `ODC_CMD_WDIR:  wdir      <= w_q[1:0];
                    `ODC_CMD_SDIR:  scan_dir  <= w_q[0];
                    // R19 host keeps start not above end
                    `ODC_CMD_AREA: if (pidx == 3'h7) begin
                        ax_s <= next_stage[24+:XW];
                        ax_e <= next_stage[16+:XW];
                        ay_s <= next_stage[8+:YW];
                        ay_e <= next_stage[0+:YW];
                    end
                    `ODC_CMD_BOX: if (pidx == 3'h7) begin
                        bx_s <= next_stage[24+:XW];
                        bx_e <= next_stage[16+:XW];
                        by_s <= next_stage[8+:YW];
                        by_e <= next_stage[0+:YW];
                    end
                    `ODC_CMD_START: if (pidx == 3'h3) begin
                        st_x <= next_stage[8+:XW];
                        st_y <= next_stage[0+:YW];
                    end
                    default: ;
                endcase
            end
            if (wr_fire && aw_q == `ODC_OFF_TIMING) begin
                for (int b = 0; b < 4; b++) begin
                    if (ws_q[b]) begin
                        timing[8*b+:8] <= w_q[8*b+:8];
                    end
                end
            end
        end
    end

    // ---------------------------------------------
    // frame memory writes
    // ---------------------------------------------
    // box corners loaded into the pointer, fresh ones on the box command
    assign lx_s    = box_done ? next_stage[24+:XW] : bx_s;
    assign lx_e    = box_done ? next_stage[16+:XW] : bx_e;
    assign ly_s    = box_done ? next_stage[8+:YW] : by_s;
    assign ly_e    = box_done ? next_stage[0+:YW] : by_e;
    assign px_fire = par_hit && cmd == `ODC_CMD_DATA && wr_state == odc_pkg::wr_busy;
    assign x_end   = wdir[0] ? wx == bx_s : wx == bx_e;
    assign y_end   = wdir[1] ? wy == by_s : wy == by_e;

    // R07 store only inside the box
    assign mem_bus.we    = px_fire && wx >= bx_s && wx <= bx_e && wy >= by_s && wy <= by_e;
    assign mem_bus.waddr = {wy, wx};
    assign mem_bus.wdata = w_q[15:0];

    // write pointer; any other command ends a pixel stream
    always_ff @(posedge aclk) begin : wr_pointer
        if (defaults) begin
            wx       <= '0;
            wy       <= '0;
            wr_state <= odc_pkg::wr_idle;
        end else if (data_start || box_done) begin
            wx       <= wdir[0] ? lx_e : lx_s;
            wy       <= wdir[1] ? ly_e : ly_s;
            wr_state <= data_start ? odc_pkg::wr_busy : odc_pkg::wr_idle;
        end else begin
            case (wr_state)
                odc_pkg::wr_idle: ;
                odc_pkg::wr_busy: begin
                    if (cmd_hit) begin
                        wr_state <= odc_pkg::wr_idle;
                    end else if (px_fire) begin
                        // R08 step along x, then y
                        wx <= x_end ? (wdir[0] ? bx_e : bx_s)
                                    : (wdir[0] ? XW'(wx - 1'b1) : XW'(wx + 1'b1));
                        if (x_end) begin
                            wy <= wdir[1] ? YW'(wy - 1'b1) : YW'(wy + 1'b1);
                        end
                        if (x_end && y_end) begin
                            wr_state <= odc_pkg::wr_idle;
                        end
                    end
                end
                default: wr_state <= odc_pkg::wr_idle;
            endcase
        end
    end

    // R02 frame memory of 327,680 bits
    odc_frame_mem #(
        .DEPTH (NCOL * NROW),
        .WIDTH (16)
    ) u_mem (
        .aclk (aclk),
        .mp   (mem_bus.mem)
    );

    // ---------------------------------------------
    // dot clock
    // ---------------------------------------------
    assign osc_run = !standby;

    // R15 dot tick from the system clock, held still in standby
    always_ff @(posedge aclk) begin : dot_clock
        if (defaults || !osc_run) begin
            osc_cnt  <= '0;
            dot_tick <= 1'b0;
        end else if (osc_cnt >= 8'(osc_div(frame_sel) - 1'b1)) begin
            osc_cnt  <= '0;
            dot_tick <= 1'b1;
        end else begin
            osc_cnt  <= 8'(osc_cnt + 1'b1);
            dot_tick <= 1'b0;
        end
    end

    // ---------------------------------------------
    // row scan and line fetch
    // ---------------------------------------------
    // R06 R18 line length ignores the active area, one line per active row per frame, not 160
    assign line_len = 10'(timing[7:0]) + 10'(timing[15:8]) + 10'(timing[23:16])
                    + `ODC_LINE_DATA;
    assign pk_end   = 10'(timing[7:0]) + 10'(timing[23:16]) + 10'(timing[15:8]);
    assign lit      = disp_on && osc_run;

    // R05 line counter and row sequencer
    always_ff @(posedge aclk) begin : scan
        if (defaults) begin
            line_pos  <= '0;
            cur_row   <= '0;
            fetch_row <= '0;
        end else if (dot_tick) begin
            if (line_pos >= 10'(line_len - 1'b1)) begin
                line_pos  <= '0;
                cur_row   <= fetch_row;
                fetch_row <= row_step(fetch_row);
            end else begin
                line_pos <= 10'(line_pos + 1'b1);
            end
        end
    end

    // R09 R10 read address from start point, wrapping over all memory
    assign mem_bus.raddr = {mem_row(fetch_row), XW'(st_x + fc[XW-1:0] - ax_s)};

    // fetch the next line while the current one is shown
    always_ff @(posedge aclk) begin : fetch
        if (defaults) begin
            fc   <= {1'b1, {XW{1'b0}}};
            fc_d <= '0;
            fv   <= 1'b0;
        end else begin
            if (dot_tick && line_pos >= 10'(line_len - 1'b1)) begin
                fc <= '0;
            end else if (!fc[XW]) begin
                fc <= (XW+1)'(fc + 1'b1);
            end
            fv   <= !fc[XW];
            fc_d <= fc[XW-1:0];
        end
    end

    // line buffers; data only move to the drivers while displaying
    always_ff @(posedge aclk) begin : line_bufs
        if (fv) begin
            fetch_buf[fc_d] <= mem_bus.rdata;
        end
        // R17 no transfer while off
        if (lit && dot_tick && line_pos >= 10'(line_len - 1'b1)) begin
            line_buf <= fetch_buf;
        end
    end

    // ---------------------------------------------
    // driver outputs
    // ---------------------------------------------
    // one cycle behind the line counter; widths compare in dot clocks
    always_ff @(posedge aclk) begin : drive_out
        // R17 R21 dark until running and on
        if (defaults || !lit) begin
            col_pre   <= '1;
            col_drive <= '0;
            row_gnd   <= '1;
        end else begin
            for (int i = 0; i < NCOL; i++) begin
                for (int k = 0; k < 3; k++) begin
                    // R03 outside columns stay pre-charged
                    col_pre[3*i+k] <= XW'(i) < ax_s || XW'(i) > ax_e
                                      || line_pos < 10'(timing[7:0]);
                    // R11 R22 pulse counted from data start
                    col_drive[3*i+k] <= XW'(i) >= ax_s && XW'(i) <= ax_e && (
                        (line_pos >= 10'(timing[7:0]) + 10'(timing[23:16])
                         && line_pos < pk_end && sub_w(line_buf[i], k) != 8'h00)
                        || (line_pos >= pk_end
                         && 10'(line_pos - pk_end) < 10'(sub_w(line_buf[i], k))));
                end
            end
            for (int j = 0; j < NROW; j++) begin
                // R04 R16 only the scanned row falls, after the overlap
                row_gnd[j] <= YW'(j) == cur_row && YW'(j) >= ay_s && YW'(j) <= ay_e
                              && line_pos >= 10'(timing[31:24]);
            end
        end
    end
endmodule : odc_display_ctrl

// [verification/odc_checker.sv]
// port assertions of the display state controller
module odc_checker #(
    parameter int NCOL = 128,
    parameter int NROW = 160
) (
    // clock and reset
    input wire logic aclk, aresetn,
    // bus handshakes
    input wire logic awvalid, awready, wvalid, wready, bvalid, bready,
    input wire logic arvalid, arready, rvalid, rready,
    input wire logic [1:0] bresp,
    input wire logic [31:0] rdata,
    // panel drivers
    input wire logic [3*NCOL-1:0] col_pre, col_drive,
    input wire logic [NROW-1:0] row_gnd
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_pre_excludes_drive: assert property ((col_drive & col_pre) == '0)
        else $error("column driven while pre-charged");
    a_drive_needs_row: assert property (|col_drive |-> !(&row_gnd))
        else $error("column driven with all rows grounded");
    a_single_row: assert property (!(&row_gnd) |-> $countones(row_gnd) <= 1)
        else $error("more than one row selected");
    a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
        else $error("write response missing");
    a_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read data missing");
    a_bresp_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    a_rdata_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    a_write_refused: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while response pending");
    a_read_refused: assert property (rvalid |-> !arready)
        else $error("read taken while data pending");
    // main scenarios reached
    cover property (bvalid && bready);
    cover property (rvalid && rready);
    cover property (|col_drive);
endmodule : odc_checker

// [verification/odc_host.sv]
// host model: axi4-lite master issuing commands and parameters
module odc_host (
    // clock
    input wire logic aclk,
    // master side
    output logic [7:0] awaddr, araddr,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic awvalid, wvalid, bready, arvalid, rready,
    // slave answers
    input wire logic awready, wready, bvalid, arready, rvalid,
    input wire logic [1:0] bresp, rresp,
    input wire logic [31:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    initial wstrb = 4'hF;
    // address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (awvalid && !awready || wvalid && !wready);
        do @(posedge aclk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask : wr
    // read address released when taken, rready held until data seen
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        {d, r} = {rdata, rresp};
        rready <= 1'b0;
    endtask : rd
endmodule : odc_host

// [verification/testbench.sv]
// testbench of the display state controller
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, keep;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, v;
    logic [3:0] wstrb, drv;
    logic [1:0] bresp, rresp, r;
    logic [383:0] col_pre, col_drive;
    logic [159:0] row_gnd, seen;
    int miscompares, samples_checked;
    odc_display_ctrl uut (.*);
    odc_host host (.*);
    task automatic chk(input string n, input logic [159:0] e, g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] m, e);
        host.rd(a, v, r);
        chk(n, e, v & m);
    endtask : rdc
    task automatic cmd(input logic [7:0] c, p);
        host.wr(8'h00, {24'h0, c}, r);
        host.wr(8'h04, {24'h0, p}, r);
    endtask : cmd
    task automatic report_and_stop;
        $display("checks %0d miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // watchdog: the run needs about 36k cycles
    initial begin
        #500_000;
        miscompares++;
        report_and_stop();
    end
    initial begin
        {aresetn, miscompares, samples_checked} = '0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rdc("area", 8'h10, '1, 32'h9F00_7F00);
        rdc("status", 8'h0C, 32'h7, 32'h2);
        rdc("timing", 8'h08, '1, 32'h0001_0A10);
        host.wr(8'h14, 32'h0, r);
        chk("unmapped", 2'h2, r);
        cmd(8'h03, 8'h00);
        rdc("osc only", 8'h0C, 32'h7, 32'h4);
        // area x 2..5, y 3..6, one nibble a write
        host.wr(8'h00, 32'h7, r);
        for (int i = 7; i >= 0; i--) host.wr(8'h04, {28'h0, 4'(32'h0205_0306 >> 4*i)}, r);
        rdc("area set", 8'h10, '1, 32'h0603_0502);
        host.wr(8'h00, 32'h0000_000C, r);
        host.wr(8'h04, 32'h0000_FFFF, r);
        rdc("step", 8'h0C, 32'h7F00_0008, 32'h0100_0008);
        cmd(8'h02, 8'h01);
        rdc("on", 8'h0C, 32'h7, 32'h5);
        {seen, keep, drv} = {160'h0, 1'b1, 4'h0};
        repeat (36000) @(negedge aclk) begin
            seen |= row_gnd;
            drv |= 4'(col_drive[8:6]);
            keep &= &{col_pre[383:18], col_pre[5:0]};
        end
        chk("rows scanned", 160'h78, seen);
        chk("pre outside", 1'b1, keep);
        chk("pixel drive", 4'h7, drv);
        cmd(8'h02, 8'h00);
        rdc("off", 8'h0C, 32'h7, 32'h4);
        chk("rows off", '1, row_gnd);
        chk("drive off", 1'b0, |col_drive);
        cmd(8'h03, 8'h01);
        rdc("standby", 8'h0C, 32'h7, 32'h2);
        cmd(8'h03, 8'h00);
        host.wr(8'h00, 32'h1, r);
        rdc("soft status", 8'h0C, 32'h7, 32'h2);
        rdc("soft area", 8'h10, '1, 32'h9F00_7F00);
        report_and_stop();
    end
endmodule : testbench
bind odc_display_ctrl odc_checker #(.NCOL(NCOL), .NROW(NROW)) u_chk (.*);
